// *** logic/rtfsm_defines.svh ***
// Timing counts and field constants for the transponder protocol timing block
`ifndef RTFSM_DEFINES_SVH
`define RTFSM_DEFINES_SVH
`define RTFSM_REPLY_DELAY_MIN 8'd204
`define RTFSM_REPLY_DELAY_TYP 8'd209
`define RTFSM_REPLY_DELAY_MAX 8'd213
`define RTFSM_HOLD_OFF 9'd150
`define RTFSM_QUIET_EOF_TAIL 9'd42
`define RTFSM_STOP_COND 6'd42
`define RTFSM_BIT_PERIOD 9'd32
`define RTFSM_SOF_BITS 9'd3
`define RTFSM_EMPTY_SLOT_WAIT 9'd309
`define RTFSM_LISTEN_WINDOW 10'd545
`define RTFSM_POWER_UP_NS 32'd2330000
`define RTFSM_UID_BITS 48
`define RTFSM_TTF_BITS 128
`endif

// *** logic/rtfsm_link_if.sv ***
// Link between reader and transponder: field, modulation and reply
`timescale 1ns/1ps
interface rtfsm_link_if;
    logic carrier_clk;
    logic field_on;
    logic modulation;
    logic tag_reply;
    modport tag (input carrier_clk, input field_on, input modulation, output tag_reply);
    modport reader (output carrier_clk, output field_on, output modulation, input tag_reply);
endinterface

// *** logic/rtfsm_pkg.sv ***
// Types shared by both ends of the transponder protocol link
package rtfsm_pkg;
    typedef enum logic [2:0] {
        RTFSM_ST_TTF = 3'b000,
        RTFSM_ST_WAIT = 3'b001,
        RTFSM_ST_READY = 3'b010,
        RTFSM_ST_SELECTED = 3'b011,
        RTFSM_ST_QUIET = 3'b100
    } rtfsm_state_e;
    typedef enum logic [2:0] {
        RTFSM_CMD_NONE = 3'b000,
        RTFSM_CMD_GENERIC = 3'b001,
        RTFSM_CMD_QUIET = 3'b010,
        RTFSM_CMD_SELECT = 3'b011,
        RTFSM_CMD_WRITE_ISO = 3'b100,
        RTFSM_CMD_INVENTORY = 3'b101,
        RTFSM_CMD_SWITCH = 3'b110
    } rtfsm_cmd_e;
endpackage

// *** logic/rtfsm_reader.sv ***
// Reader end: carrier generation and gap timing between requests
`timescale 1ns/1ps
module rtfsm_reader #(
    parameter int CLK_DIV = 372,
    parameter int POWER_UP_CYC = 233000
) (
    rtfsm_link_if.reader link,
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic field_req,
    input wire logic req_start,
    input wire logic req_after_quiet,
    input wire logic req_inventory,
    input wire logic reply_seen,
    input wire logic reply_done,
    input wire logic [5:0] mask_len,
    input wire logic crc_flag,
    input wire logic mod_req,
    output logic ready_to_send,
    output logic [11:0] nominal_reply_time,
    output logic field_q_out
);
    import rtfsm_pkg::*;
    `include "rtfsm_defines.svh"

    logic [8:0] div_q;
    logic clk_q;
    logic field_q;
    logic mod_q;
    logic [17:0] pwr_cnt_q;
    logic [8:0] gap_cnt_q;
    logic [8:0] gap_need_q;
    logic ready_q;
    logic [11:0] nrt_q;

    // Carrier derived by divider
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 9'h000;
            clk_q <= 1'b0;
        end else if (div_q == 9'(CLK_DIV / 2 - 1)) begin
            div_q <= 9'h000;
            clk_q <= ~clk_q;
        end else begin
            div_q <= div_q + 9'h001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            field_q <= 1'b0;
            mod_q <= 1'b0;
        end else begin
            field_q <= field_req;
            mod_q <= mod_req & field_req;
        end
    end

    // Power-up wait
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_cnt_q <= 18'h00000;
        end else if (!field_q) begin
            pwr_cnt_q <= 18'h00000;
        end else if (pwr_cnt_q != 18'(POWER_UP_CYC)) begin
            pwr_cnt_q <= pwr_cnt_q + 18'h00001;
        end
    end

    // Gap timer in carrier periods
    logic tick;
    assign tick = (div_q == 9'h000) && clk_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt_q <= 9'h000;
            gap_need_q <= 9'h000;
        end else if (req_start) begin
            gap_cnt_q <= 9'h000;
            if (req_after_quiet) begin
                gap_need_q <= `RTFSM_HOLD_OFF + `RTFSM_QUIET_EOF_TAIL;
            end else begin
                gap_need_q <= `RTFSM_EMPTY_SLOT_WAIT;
            end
        end else if (reply_seen && !reply_done) begin
            gap_cnt_q <= 9'h000;
            gap_need_q <= 9'h1FF;
        end else if (reply_done) begin
            gap_cnt_q <= 9'h000;
            gap_need_q <= `RTFSM_HOLD_OFF;
        end else if (tick && gap_cnt_q != 9'h1FF) begin
            gap_cnt_q <= gap_cnt_q + 9'h001;
        end
    end

    // Nominal reply time: SOF, flag, UID rest, optional checksum
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            nrt_q <= 12'h000;
            ready_q <= 1'b0;
        end else begin
            nrt_q <= 12'(`RTFSM_SOF_BITS + 9'd1 + (crc_flag ? 9'd16 : 9'd0)) * 12'(`RTFSM_BIT_PERIOD)
                + 12'(6'd48 - mask_len) * 12'd64;
            ready_q <= field_q && pwr_cnt_q == 18'(POWER_UP_CYC) && gap_cnt_q >= gap_need_q
                && (!req_inventory || mask_len <= 6'd48);
        end
    end

    assign link.carrier_clk = clk_q;
    assign link.field_on = field_q;
    assign link.modulation = mod_q;
    assign ready_to_send = ready_q;
    assign nominal_reply_time = nrt_q;
    assign field_q_out = field_q;
endmodule

// *** logic/rtfsm_tag.sv ***
// Transponder end: reply delay, mode and protocol state
//
// Overview of operation
// - Wait reply delay after EOF falling edge
// - Modulation during delay restarts the timer
// - Reader holds off 150 periods after reply
// - After quiet, hold off 192 periods total
// - Reader waits 2.33 ms after field on
// - Inventory reply seen: wait end plus 150
// - Empty slot: wait max delay plus SOF
// - Nominal reply time from mask and checksum
// - Enter waiting state on leaving tag-talks-first
// - Valid command moves tag to ready
// - Own select gives selected; SEL commands only there
// - Foreign select drops selected tag to quiet
// - Stay-quiet gives quiet; answer addressed only
// - Invalid command keeps state; in TTF an invalid switch command in the listen window still gives WAIT
// - Start tag-talks-first, then stream 128 bits
// - Command in listen window switches to reader-talks-first
// - Reader-talks-first: act only on valid requests
// - Reader starts inventory with mask length limits
// - One-slot inventory: mask match sends UID rest
// - Inventory replies use dual-pattern coding
// - EOF is pulse then 42 idle periods
`timescale 1ns/1ps
module rtfsm_tag #(
    parameter int UID_BITS = `RTFSM_UID_BITS,
    parameter int TTF_BITS = `RTFSM_TTF_BITS
) (
    rtfsm_link_if.tag link,
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [UID_BITS-1:0] uid,
    input wire logic [TTF_BITS-1:0] ttf_data,
    input wire logic cmd_valid,
    input wire rtfsm_pkg::rtfsm_cmd_e cmd_kind,
    input wire logic cmd_ok,
    input wire logic cmd_uid_match,
    input wire logic cmd_sel_flag,
    input wire logic cmd_adr_flag,
    input wire logic cmd_one_slot,
    input wire logic [5:0] cmd_mask_len,
    input wire logic [UID_BITS-1:0] cmd_mask,
    output logic [2:0] tag_state,
    output logic reply_go,
    output logic reply_dual_pattern,
    output logic [5:0] reply_bits_left,
    output logic ttf_bit
);
    import rtfsm_pkg::*;
    `include "rtfsm_defines.svh"

    // Carrier domain: field loss is the reset
    logic field_rst_b;
    assign field_rst_b = rst_b & link.field_on;

    logic mod_prev_q, mod_s1_q, mod_s2_q, eof_seen_q, delay_run_q, reply_pend_q, go_tgl_q;
    logic [5:0] idle_cnt_q, left_q;
    logic [7:0] delay_cnt_q;
    logic [9:0] listen_cnt_q;
    logic [6:0] ttf_idx_q;
    logic cmd_sync1_q, cmd_sync2_q, ttf_s1_q, ttf_s2_q, ttf_q, dual_q, ttf_bit_q;
    rtfsm_state_e state_q;
    logic listen_open, mod_fall;
    assign mod_fall = mod_prev_q & ~mod_s2_q;
    assign listen_open = listen_cnt_q < `RTFSM_LISTEN_WINDOW;

    always_ff @(posedge link.carrier_clk or negedge field_rst_b) begin
        if (!field_rst_b) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
            mod_prev_q <= 1'b0;
        end else begin
            mod_s1_q <= link.modulation;
            mod_s2_q <= mod_s1_q;
            mod_prev_q <= mod_s2_q;
        end
    end

    // Stop condition: pulse then 42 idle periods
    always_ff @(posedge link.carrier_clk or negedge field_rst_b) begin
        if (!field_rst_b) begin
            idle_cnt_q <= 6'h00;
            eof_seen_q <= 1'b0;
        end else if (mod_s2_q) begin
            idle_cnt_q <= 6'h00;
            eof_seen_q <= 1'b0;
        end else if (mod_fall) begin
            idle_cnt_q <= 6'h01;
            eof_seen_q <= 1'b0;
        end else if (idle_cnt_q != 6'h00 && idle_cnt_q < `RTFSM_STOP_COND) begin
            idle_cnt_q <= idle_cnt_q + 6'h01;
            eof_seen_q <= (idle_cnt_q + 6'h01) == `RTFSM_STOP_COND;
        end else begin
            eof_seen_q <= 1'b0;
        end
    end

    // Command events cross into the carrier domain
    always_ff @(posedge link.carrier_clk or negedge field_rst_b) begin
        if (!field_rst_b) begin
            cmd_sync1_q <= 1'b0;
            cmd_sync2_q <= 1'b0;
            ttf_s1_q <= 1'b0;
            ttf_s2_q <= 1'b0;
        end else begin
            cmd_sync1_q <= reply_pend_q;
            cmd_sync2_q <= cmd_sync1_q;
            ttf_s1_q <= ttf_q;
            ttf_s2_q <= ttf_s1_q;
        end
    end
    // Reply delay timer, measured from EOF falling edge
    always_ff @(posedge link.carrier_clk or negedge field_rst_b) begin
        if (!field_rst_b) begin
            delay_cnt_q <= 8'h00;
            delay_run_q <= 1'b0;
            go_tgl_q <= 1'b0;
        end else if (delay_run_q && mod_s2_q) begin
            delay_cnt_q <= 8'h00;
        end else if (eof_seen_q && cmd_sync2_q && !delay_run_q) begin
            delay_run_q <= 1'b1;
            delay_cnt_q <= {2'b00, `RTFSM_STOP_COND};
        end else if (delay_run_q) begin
            // Three edges less for the modulation synchroniser
            if (delay_cnt_q == `RTFSM_REPLY_DELAY_TYP - 8'h03) begin
                delay_run_q <= 1'b0;
                go_tgl_q <= ~go_tgl_q;
                delay_cnt_q <= 8'h00;
            end else begin
                delay_cnt_q <= delay_cnt_q + 8'h01;
            end
        end
    end

    // Listening window and tag-talks-first stream
    always_ff @(posedge link.carrier_clk or negedge field_rst_b) begin
        if (!field_rst_b) begin
            listen_cnt_q <= 10'h000;
            ttf_idx_q <= 7'h00;
            ttf_bit_q <= 1'b0;
        end else begin
            if (listen_open) begin
                listen_cnt_q <= listen_cnt_q + 10'h001;
            end
            if (!listen_open && ttf_s2_q) begin
                ttf_bit_q <= ttf_data[ttf_idx_q];
                ttf_idx_q <= ttf_idx_q + 7'h01;
            end else begin
                ttf_bit_q <= 1'b0;
            end
        end
    end
    assign link.tag_reply = ttf_bit_q;

    // Core domain: listen-window flag and go toggle synchronised
    logic win_s1_q, win_s2_q, go_s1_q, go_s2_q, go_prev_q, go_q, go_out_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_s1_q <= 1'b0;
            win_s2_q <= 1'b0;
            go_s1_q <= 1'b0;
            go_s2_q <= 1'b0;
            go_prev_q <= 1'b0;
            go_q <= 1'b0;
            go_out_q <= 1'b0;
            ttf_q <= 1'b1;
        end else begin
            win_s1_q <= listen_open & link.field_on;
            win_s2_q <= win_s1_q;
            go_s1_q <= go_tgl_q;
            go_s2_q <= go_s1_q;
            go_prev_q <= go_s2_q;
            go_q <= go_s2_q ^ go_prev_q;
            go_out_q <= go_q & reply_pend_q;
            ttf_q <= state_q == RTFSM_ST_TTF;
        end
    end

    // Request acceptance per state
    logic accept;
    always_comb begin
        accept = cmd_valid & cmd_ok & (cmd_kind != RTFSM_CMD_NONE);
        if (state_q == RTFSM_ST_QUIET && !cmd_adr_flag) begin
            accept = 1'b0;
        end
        if (cmd_sel_flag && state_q != RTFSM_ST_SELECTED) begin
            accept = 1'b0;
        end
        if (cmd_kind == RTFSM_CMD_INVENTORY && state_q != RTFSM_ST_READY && state_q != RTFSM_ST_WAIT) begin
            accept = 1'b0;
        end
    end

    // Protocol state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= RTFSM_ST_TTF;
        end else if (!link.field_on) begin
            state_q <= RTFSM_ST_TTF;
        end else if (state_q == RTFSM_ST_TTF) begin
            if (cmd_valid && win_s2_q && (cmd_ok || cmd_kind == RTFSM_CMD_SWITCH)) begin
                state_q <= RTFSM_ST_WAIT;
            end
        end else if (accept) begin
            case (cmd_kind)
                RTFSM_CMD_QUIET: begin
                    state_q <= RTFSM_ST_QUIET;
                end
                RTFSM_CMD_SELECT: begin
                    if (cmd_uid_match) begin
                        state_q <= RTFSM_ST_SELECTED;
                    end else if (state_q == RTFSM_ST_SELECTED) begin
                        state_q <= RTFSM_ST_QUIET;
                    end
                end
                RTFSM_CMD_WRITE_ISO: begin
                    state_q <= state_q;
                end
                default: begin
                    if (state_q != RTFSM_ST_SELECTED) begin
                        state_q <= RTFSM_ST_READY;
                    end
                end
            endcase
        end
    end

    // Reply pending and inventory reply shape
    logic mask_hit;
    always_comb begin
        mask_hit = 1'b1;
        for (int i = 0; i < UID_BITS; i++) begin
            if (i < int'(cmd_mask_len) && uid[i] != cmd_mask[i]) begin
                mask_hit = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_pend_q <= 1'b0;
            dual_q <= 1'b0;
            left_q <= 6'h00;
        end else if (go_q || !link.field_on) begin
            reply_pend_q <= 1'b0;
        end else if (accept && state_q != RTFSM_ST_TTF && cmd_kind != RTFSM_CMD_SWITCH) begin
            if (cmd_kind == RTFSM_CMD_INVENTORY) begin
                reply_pend_q <= cmd_one_slot & mask_hit;
                dual_q <= 1'b1;
                left_q <= 6'(UID_BITS) - cmd_mask_len;
            end else begin
                reply_pend_q <= 1'b1;
                dual_q <= 1'b0;
                left_q <= 6'h00;
            end
        end
    end

    assign tag_state = state_q;
    assign reply_go = go_out_q;
    assign reply_dual_pattern = dual_q;
    assign reply_bits_left = left_q;
    assign ttf_bit = ttf_bit_q;
endmodule

// *** verif/rtfsm_link_props.sv ***
// Checker for the reader to transponder link and the transponder outputs
`timescale 1ns/1ps
module rtfsm_link_props #(
    parameter int POWER_UP_CYC = 100
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic carrier_clk,
    input wire logic field_on,
    input wire logic modulation,
    input wire logic tag_reply,
    input wire logic [2:0] tag_state,
    input wire logic reply_go,
    input wire logic ready_to_send,
    input wire logic reply_done,
    input wire logic req_start
);
    import rtfsm_pkg::*;
    logic [2:0] cs_q;
    logic [9:0] mcnt_q;
    logic [9:0] hcnt_q;
    logic arm_q;
    logic [17:0] pcnt_q;
    wire ce = cs_q[1] & ~cs_q[2];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Carrier edge seen from the core clock
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) cs_q <= 3'h0;
        else cs_q <= {cs_q[1:0], carrier_clk};
    end
    // Carrier periods since the last modulation
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) mcnt_q <= 10'h0;
        else if (modulation) mcnt_q <= 10'h0;
        else if (ce && mcnt_q != 10'h3FF) mcnt_q <= mcnt_q + 10'h1;
    end
    // Carrier periods since the last reply ended
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) hcnt_q <= 10'h0;
        else if (reply_done) hcnt_q <= 10'h0;
        else if (ce && hcnt_q != 10'h3FF) hcnt_q <= hcnt_q + 10'h1;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) arm_q <= 1'b0;
        else if (reply_done) arm_q <= 1'b1;
        else if (req_start) arm_q <= 1'b0;
    end
    // Core cycles since the field came up
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) pcnt_q <= 18'h0;
        else if (!field_on) pcnt_q <= 18'h0;
        else if (pcnt_q != 18'h3FFFF) pcnt_q <= pcnt_q + 18'h1;
    end
    AST_REPLY_DELAY: assert property (reply_go |-> mcnt_q >= 10'd195 && mcnt_q <= 10'd212)
        else $error("reply outside the reply delay");
    AST_REPLY_PULSE: assert property (reply_go |=> !reply_go)
        else $error("reply start longer than one cycle");
    AST_NO_TTF_REPLY: assert property (reply_go |-> tag_state != RTFSM_ST_TTF)
        else $error("reply while talking first");
    AST_TTF_EXIT: assert property ($past(tag_state) == RTFSM_ST_TTF && tag_state != RTFSM_ST_TTF
        |-> tag_state == RTFSM_ST_WAIT)
        else $error("mode switch not into waiting state");
    AST_FIELD_OFF: assert property ($fell(field_on) |-> ##[0:40] tag_state == RTFSM_ST_TTF)
        else $error("field loss did not restart talk-first mode");
    AST_POWER_UP: assert property (ready_to_send && field_on |-> pcnt_q >= POWER_UP_CYC - 2)
        else $error("reader ready before power-up wait");
    AST_HOLD_OFF: assert property (ready_to_send && arm_q && $past(arm_q) |-> hcnt_q >= 10'd149)
        else $error("reader ready before hold-off");
    AST_STATE_LEGAL: assert property (tag_state <= 3'h4)
        else $error("illegal protocol state");
endmodule

// *** verif/tb.sv ***
// Self-checking bench joining reader and transponder over the link
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin n_mismatch++; \
    $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb;
    import rtfsm_pkg::*;
    localparam int DIV = 16;
    logic core_clk = 0;
    logic rst_b = 0;
    logic field_req = 0, req_start = 0, req_after_quiet = 0, req_inventory = 0;
    logic reply_seen = 0, reply_done = 0, crc_flag = 0, mod_req = 0;
    logic [5:0] mask_len = 0;
    logic [47:0] uid = 0, cmd_mask = 0;
    logic [127:0] ttf_data = 0;
    logic cmd_valid = 0, cmd_ok = 0, cmd_uid_match = 0, cmd_sel_flag = 0, cmd_adr_flag = 0, cmd_one_slot = 0;
    rtfsm_cmd_e cmd_kind = RTFSM_CMD_NONE;
    logic [5:0] cmd_mask_len = 0;
    logic [2:0] tag_state;
    logic reply_go, reply_dual_pattern, ttf_bit, ready_to_send, field_q_out;
    logic [5:0] reply_bits_left;
    logic [11:0] nominal_reply_time, nrt_a;
    logic [5:0] exp_q[$];
    bit may_r = 0;
    int n_tests = 0, n_mismatch = 0, n_edges = 0;
    int n1, n2;
    always #5 core_clk = ~core_clk;
    rtfsm_link_if lnk();
    rtfsm_reader #(.CLK_DIV(DIV), .POWER_UP_CYC(100)) u_rtfsm_reader (.link(lnk), .core_clk(core_clk),
        .rst_b(rst_b), .field_req(field_req), .req_start(req_start), .req_after_quiet(req_after_quiet),
        .req_inventory(req_inventory), .reply_seen(reply_seen), .reply_done(reply_done), .mask_len(mask_len),
        .crc_flag(crc_flag), .mod_req(mod_req), .ready_to_send(ready_to_send),
        .nominal_reply_time(nominal_reply_time), .field_q_out(field_q_out));
    rtfsm_tag u_rtfsm_tag (.link(lnk), .core_clk(core_clk), .rst_b(rst_b), .uid(uid), .ttf_data(ttf_data),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ok(cmd_ok), .cmd_uid_match(cmd_uid_match),
        .cmd_sel_flag(cmd_sel_flag), .cmd_adr_flag(cmd_adr_flag), .cmd_one_slot(cmd_one_slot),
        .cmd_mask_len(cmd_mask_len), .cmd_mask(cmd_mask), .tag_state(tag_state), .reply_go(reply_go),
        .reply_dual_pattern(reply_dual_pattern), .reply_bits_left(reply_bits_left), .ttf_bit(ttf_bit));
    rtfsm_link_props #(.POWER_UP_CYC(100)) u_rtfsm_link_props (.core_clk(core_clk), .rst_b(rst_b),
        .carrier_clk(lnk.carrier_clk), .field_on(lnk.field_on), .modulation(lnk.modulation),
        .tag_reply(lnk.tag_reply), .tag_state(tag_state), .reply_go(reply_go), .ready_to_send(ready_to_send),
        .reply_done(reply_done), .req_start(req_start));
    always @(lnk.tag_reply) n_edges++;
    // Reply monitor against noted expectations
    always @(posedge core_clk) begin
        if (reply_go === 1'b1) begin
            if (exp_q.size() > 0) begin
                `CHK("bits_left", exp_q[0], reply_bits_left)
                `CHK("dual_pattern", 1'b1, reply_dual_pattern)
                void'(exp_q.pop_front());
            end else if (!may_r) begin
                `CHK("reply", 1'b0, reply_go)
            end
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask
    task automatic eof();
        mod_req = 1;
        tick(6 * DIV);
        mod_req = 0;
    endtask
    task automatic step(input rtfsm_cmd_e k, input logic [4:0] f, input logic [5:0] n, input logic [47:0] m,
        input logic [2:0] st, input bit may, input bit r);
        may_r = may;
        if (r) exp_q.push_back(6'(48 - n));
        cmd_kind = k;
        {cmd_ok, cmd_uid_match, cmd_sel_flag, cmd_adr_flag, cmd_one_slot} = f;
        cmd_mask_len = n;
        cmd_mask = m;
        pulse(cmd_valid);
        tick(2);
        `CHK("state", st, tag_state)
        eof();
        if (r) begin
            tick(100 * DIV);
            eof();
        end
        tick(225 * DIV);
        `CHK("missing_reply", 0, exp_q.size())
        exp_q.delete();
    endtask
    task automatic gap(input logic q, input logic inv, input logic sn, input int lo, input int hi);
        req_after_quiet = q;
        req_inventory = inv;
        pulse(req_start);
        if (sn) begin
            tick(DIV);
            pulse(reply_seen);
            tick(DIV);
            pulse(reply_done);
        end
        tick(lo * DIV);
        `CHK("gap_early", 1'b0, ready_to_send)
        tick((hi - lo) * DIV);
        `CHK("gap_late", 1'b1, ready_to_send)
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #950_000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h9720f720));
        uid = {16'($urandom()), $urandom()};
        ttf_data = {$urandom(), $urandom(), $urandom(), $urandom()};
        n1 = $urandom_range(48, 0);
        n2 = $urandom_range(48, 1);
        tick(10);
        rst_b = 1;
        tick(2);
        field_req = 1;
        tick(50);
        `CHK("power_early", 1'b0, ready_to_send)
        tick(150);
        `CHK("power_late", 1'b1, ready_to_send)
        `CHK("ttf_start", RTFSM_ST_TTF, tag_state)
        tick(400 * DIV);
        step(RTFSM_CMD_SWITCH, 5'b10000, 0, 0, RTFSM_ST_WAIT, 0, 0);
        step(RTFSM_CMD_GENERIC, 5'b00000, 0, 0, RTFSM_ST_WAIT, 0, 0);
        step(RTFSM_CMD_NONE, 5'b10000, 0, 0, RTFSM_ST_WAIT, 0, 0);
        step(RTFSM_CMD_GENERIC, 5'b10100, 0, 0, RTFSM_ST_WAIT, 0, 0);
        step(RTFSM_CMD_INVENTORY, 5'b10001, 6'(n1), uid, RTFSM_ST_READY, 0, 1);
        step(RTFSM_CMD_INVENTORY, 5'b10001, 6'(n2), ~uid, RTFSM_ST_READY, 0, 0);
        step(RTFSM_CMD_SELECT, 5'b11010, 0, 0, RTFSM_ST_SELECTED, 1, 0);
        step(RTFSM_CMD_SELECT, 5'b10010, 0, 0, RTFSM_ST_QUIET, 1, 0);
        step(RTFSM_CMD_GENERIC, 5'b10000, 0, 0, RTFSM_ST_QUIET, 0, 0);
        step(RTFSM_CMD_INVENTORY, 5'b10001, 0, uid, RTFSM_ST_QUIET, 0, 0);
        step(RTFSM_CMD_WRITE_ISO, 5'b10010, 0, 0, RTFSM_ST_QUIET, 1, 0);
        step(RTFSM_CMD_GENERIC, 5'b10010, 0, 0, RTFSM_ST_READY, 1, 0);
        step(RTFSM_CMD_QUIET, 5'b10010, 0, 0, RTFSM_ST_QUIET, 1, 0);
        nrt_a = nominal_reply_time;
        crc_flag = 1;
        tick(4);
        `CHK("nrt_crc", 1'b1, nominal_reply_time > nrt_a)
        nrt_a = nominal_reply_time;
        mask_len = 6'h08;
        tick(4);
        `CHK("nrt_mask", 1'b1, nominal_reply_time < nrt_a)
        gap(1, 0, 0, 180, 205);
        gap(0, 1, 0, 300, 330);
        gap(0, 1, 1, 140, 165);
        gap(0, 0, 1, 140, 165);
        field_req = 0;
        tick(40);
        `CHK("field_off", RTFSM_ST_TTF, tag_state)
        field_req = 1;
        n_edges = 0;
        tick(600 * DIV);
        `CHK("ttf_stream", 1'b1, n_edges > 0)
        step(RTFSM_CMD_SWITCH, 5'b10000, 0, 0, RTFSM_ST_TTF, 0, 0);
        print_verdict();
    end
endmodule
